// >>> rtl/vco_cal_pkg.sv
package vco_cal_pkg;
    // Main map addresses
    localparam logic [7:0] ADDR_RDIV = 8'h02;
    localparam logic [7:0] ADDR_INTG = 8'h03;
    localparam logic [7:0] ADDR_FRAC = 8'h04;
    localparam logic [7:0] ADDR_VCO_PORT = 8'h05;
    localparam logic [7:0] ADDR_CFG = 8'h0a;
    // Field widths
    localparam int INTG_W = 19;
    localparam int FRAC_W = 24;
    localparam int RDIV_W = 14;
    localparam int SW_W = 5;
    localparam int ERR_W = 20;
    localparam int CNT_W = 28;
    localparam int WIN_W = 22;
    // Configuration field positions
    localparam int CFG_MEAS_LO = 0;
    localparam int CFG_WAIT_LO = 6;
    localparam int CFG_FREEZE = 10;
    localparam int CFG_CAL_OFF = 11;
    localparam int CFG_DIV_LO = 13;
    // Internal serial word layout
    localparam int INTERNAL_VCO_SERIAL_LINK_DATA_LO = 7;
    localparam int INTERNAL_VCO_SERIAL_LINK_ID_W = 3;
    // Cycle counts in state machine clocks
    localparam logic [4:0] XFER_CYCLES = 5'h14;
    localparam logic [4:0] XFER_DATA_CYCLES = 5'h10;
    // Reset values
    localparam logic [15:0] CFG_RESET = 16'h0000;
    localparam logic [RDIV_W-1:0] RDIV_RESET = 14'h0001;
    localparam logic [INTG_W-1:0] INTG_RESET = 19'h00014;
    // Mute sequence words
    localparam logic [23:0] VCO_PRECONFIG = 24'h000188;
    localparam logic [23:0] VCO_MUTE_DBL = 24'h002218;
    localparam logic [23:0] VCO_MUTE_FUND = 24'h002a98;
    localparam logic [23:0] VCO_UNMUTE_DBL = 24'h002018;
    localparam logic [23:0] VCO_UNMUTE_FUND = 24'h002898;
    localparam logic [23:0] VCO_CLEAR = 24'h000000;
    // Divider code that keeps the state clock under its limit
    localparam logic [1:0] DIV_SAFE = 2'h1;

    typedef enum {
        DS_IDLE, DS_XFER, DS_WAIT, DS_MEAS, DS_LOAD
    } dev_state_t;

    typedef enum {
        HS_IDLE, HS_FIRST, HS_SECOND, HS_HOLD
    } host_state_t;

    typedef enum logic [2:0] {
        OP_WRITE = 3'h0,
        OP_PRECONFIG = 3'h1,
        OP_MUTE = 3'h2,
        OP_UNMUTE = 3'h3,
        OP_BIST_MAX = 3'h4
    } host_op_t;
endpackage : vco_cal_pkg

// >>> rtl/synth_port_if.sv
`timescale 1ns/1ps
interface synth_port_if;
    logic wr_valid;
    logic [7:0] wr_addr;
    logic [23:0] wr_data;
    logic busy;
    logic cal_done;
    logic [vco_cal_pkg::SW_W-1:0] sw_state;
    logic [vco_cal_pkg::ERR_W-1:0] cal_error;

    modport host (
        output wr_valid, wr_addr, wr_data,
        input busy, cal_done, sw_state, cal_error
    );
    modport device (
        input wr_valid, wr_addr, wr_data,
        output busy, cal_done, sw_state, cal_error
    );
endinterface : synth_port_if

// >>> rtl/vco_cal_device.sv
// What this block does
// - Count VCO edges over reference-times-R-times-2^n window
// - Codes 0-3 give n=code; 4-7 give 5-8
// - Divide ratio is integer plus fraction over 2^24
// - Target is floor(N*2^n); compare measured count
// - State clock is reference divided by 2^m
// - Host keeps state clock at or below 50 MHz; reset config gives m=0, full reference rate, until host writes config
// - Each internal serial transfer lasts 20 state clocks
// - Five-bit search uses five measurement windows
// - Insert k blocks of 128 state clocks
// - Load pending fraction after final switch value
// - Same divided clock drives 16-bit serial link
// - Host picks resolution finer than eighth sub-band step
// - Host keeps N and phase detector rate legal
// - Host preconfigures enables by writing 188h once
// - Host mutes with 2218h or 2A98h
// - Host writes zero after mute to retune
// - Host unmutes with 2018h/2898h, then zero
// - Subsystem registers reachable only through port register
// - Freeze holds manual switches, varactor at mid-rail
// - Host writes switch 0, identifier 000, for maximum
// - Frozen calibration stores 20-bit signed count error
// - Fraction write calibrates, or loads directly if disabled
`timescale 1ns/1ps
module vco_cal_device (
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic resetn_i,
    // Main port from the host
    synth_port_if.device port,
    // VCO divided output pin
    input wire logic vco_pulse_i,
    // Internal serial link to the VCO subsystem
    output logic vco_serial_clock_o,
    output logic vco_serial_data_o,
    output logic vco_serial_enable_o,
    // Modulator and varactor
    output logic [vco_cal_pkg::INTG_W-1:0] mod_int_o,
    output logic [vco_cal_pkg::FRAC_W-1:0] mod_frac_o,
    output logic mod_load_o,
    output logic vtune_hold_o
);
    typedef struct packed {
        vco_cal_pkg::dev_state_t st;
        logic [4:0] div;
        logic [1:0] vsync;
        logic vprev;
        logic [vco_cal_pkg::WIN_W-1:0] win;
        logic [vco_cal_pkg::CNT_W-1:0] vcnt;
        logic [8:0] wcnt;
        logic [2:0] bitidx;
        logic [vco_cal_pkg::SW_W-1:0] sw;
        logic [4:0] xcnt;
        logic [15:0] shift;
        logic fin;
        logic manual;
        logic [vco_cal_pkg::INTG_W-1:0] intg;
        logic [vco_cal_pkg::FRAC_W-1:0] frac_pend;
        logic [vco_cal_pkg::RDIV_W-1:0] rdiv;
        logic [15:0] cfg;
        logic [15:0] vco_word;
        logic sclk;
        logic sdat;
        logic sen;
        logic [vco_cal_pkg::INTG_W-1:0] mod_int;
        logic [vco_cal_pkg::FRAC_W-1:0] mod_frac;
        logic mod_load;
        logic vhold;
        logic busy;
        logic done;
        logic [vco_cal_pkg::ERR_W-1:0] err;
    } dev_reg_t;

    dev_reg_t q;
    dev_reg_t d;

    // Measurement exponent from the 3-bit length code
    function automatic logic [3:0] meas_exp(input logic [2:0] code);
        meas_exp = code[2] ? {1'b0, code} + 4'h1 : {1'b0, code};
    endfunction : meas_exp

    // Divider mask for m = 0, 2, 4, 5
    function automatic logic [4:0] div_mask(input logic [1:0] code);
        case (code)
            2'h0: div_mask = 5'h00;
            2'h1: div_mask = 5'h03;
            2'h2: div_mask = 5'h0f;
            default: div_mask = 5'h1f;
        endcase
    endfunction : div_mask

    // Switch word keeps the host's subsystem identifier
    function automatic logic [15:0] sw_word(input logic [vco_cal_pkg::SW_W-1:0] sw,
                                            input logic [15:0] host_word);
        sw_word = {4'h0, sw, 4'h0, host_word[vco_cal_pkg::INTERNAL_VCO_SERIAL_LINK_ID_W-1:0]};
    endfunction : sw_word

    logic [3:0] n_exp;
    logic [1:0] m_code;
    logic tick;
    logic vedge;
    logic [50:0] n_scaled;
    logic [vco_cal_pkg::CNT_W-1:0] target;
    logic [vco_cal_pkg::WIN_W-1:0] win_len;
    logic [8:0] wait_len;
    logic [vco_cal_pkg::CNT_W-1:0] vfinal;
    logic cal_on;
    logic freeze;

    always_comb begin
        n_exp = meas_exp(q.cfg[vco_cal_pkg::CFG_MEAS_LO +: 3]);
        m_code = q.cfg[vco_cal_pkg::CFG_DIV_LO +: 2];
        tick = (q.div & div_mask(m_code)) == div_mask(m_code);
        vedge = q.vsync[1] & ~q.vprev;
        n_scaled = {8'h00, q.intg, q.frac_pend} << n_exp;
        target = {1'b0, n_scaled[50:24]};
        win_len = {8'h00, q.rdiv} << n_exp;
        wait_len = {q.cfg[vco_cal_pkg::CFG_WAIT_LO +: 2], 7'h00};
        vfinal = q.vcnt + {27'h0000000, vedge};
        cal_on = ~q.cfg[vco_cal_pkg::CFG_CAL_OFF];
        freeze = q.cfg[vco_cal_pkg::CFG_FREEZE];
    end

    always_comb begin
        d = q;
        d.div = q.div + 5'h01;
        d.vsync = {q.vsync[0], vco_pulse_i};
        d.vprev = q.vsync[1];
        d.mod_load = 1'b0;
        d.done = 1'b0;
        d.sclk = 1'b0;
        d.vhold = (q.st != vco_cal_pkg::DS_IDLE) || freeze;
        case (q.st)
            vco_cal_pkg::DS_IDLE: begin
                if (port.wr_valid) begin
                    case (port.wr_addr)
                        vco_cal_pkg::ADDR_RDIV: d.rdiv = port.wr_data[vco_cal_pkg::RDIV_W-1:0];
                        vco_cal_pkg::ADDR_INTG: d.intg = port.wr_data[vco_cal_pkg::INTG_W-1:0];
                        vco_cal_pkg::ADDR_CFG: d.cfg = port.wr_data[15:0];
                        vco_cal_pkg::ADDR_VCO_PORT: begin
                            d.vco_word = port.wr_data[15:0];
                            d.shift = port.wr_data[15:0];
                            d.sw = port.wr_data[vco_cal_pkg::INTERNAL_VCO_SERIAL_LINK_DATA_LO +: vco_cal_pkg::SW_W];
                            d.manual = 1'b1;
                            d.xcnt = 5'h00;
                            d.busy = 1'b1;
                            d.st = vco_cal_pkg::DS_XFER;
                        end
                        vco_cal_pkg::ADDR_FRAC: begin
                            d.frac_pend = port.wr_data[vco_cal_pkg::FRAC_W-1:0];
                            if (cal_on) begin
                                d.busy = 1'b1;
                                d.manual = 1'b0;
                                d.fin = 1'b0;
                                if (freeze) begin
                                    d.wcnt = 9'h000;
                                    d.st = vco_cal_pkg::DS_WAIT;
                                end else begin
                                    d.sw = 5'h10;
                                    d.bitidx = 3'h4;
                                    d.shift = sw_word(5'h10, q.vco_word);
                                    d.xcnt = 5'h00;
                                    d.st = vco_cal_pkg::DS_XFER;
                                end
                            end else begin
                                d.st = vco_cal_pkg::DS_LOAD;
                            end
                        end
                        default: d.busy = 1'b0;
                    endcase
                end
            end
            vco_cal_pkg::DS_XFER: begin
                if (tick) begin
                    // Enable opens on a tick, so it spans whole state clocks
                    d.sen = 1'b1;
                    d.xcnt = q.xcnt + 5'h01;
                    d.sclk = q.xcnt < vco_cal_pkg::XFER_DATA_CYCLES;
                    d.sdat = q.shift[15];
                    d.shift = {q.shift[14:0], 1'b0};
                    if (q.xcnt == vco_cal_pkg::XFER_CYCLES) begin
                        d.sen = 1'b0;
                        d.sdat = 1'b0;
                        if (q.manual) begin
                            d.busy = 1'b0;
                            d.st = vco_cal_pkg::DS_IDLE;
                        end else if (q.fin) begin
                            d.st = vco_cal_pkg::DS_LOAD;
                        end else begin
                            d.wcnt = 9'h000;
                            d.st = vco_cal_pkg::DS_WAIT;
                        end
                    end
                end
            end
            vco_cal_pkg::DS_WAIT: begin
                if (q.wcnt >= wait_len) begin
                    d.win = '0;
                    d.vcnt = '0;
                    d.st = vco_cal_pkg::DS_MEAS;
                end else if (tick) begin
                    d.wcnt = q.wcnt + 9'h001;
                end
            end
            vco_cal_pkg::DS_MEAS: begin
                d.win = q.win + 22'h000001;
                d.vcnt = vfinal;
                if (q.win + 22'h000001 >= win_len) begin
                    // Difference is cut to the field width; two's complement keeps the sign
                    d.err = 20'(vfinal - target);
                    if (freeze) begin
                        d.st = vco_cal_pkg::DS_LOAD;
                    end else begin
                        // Fast VCO keeps the trial bit, since higher switch codes tune lower
                        if (vfinal <= target) begin
                            d.sw[q.bitidx] = 1'b0;
                        end
                        if (q.bitidx == 3'h0) begin
                            d.fin = 1'b1;
                        end else begin
                            d.bitidx = q.bitidx - 3'h1;
                            d.sw[q.bitidx - 3'h1] = 1'b1;
                        end
                        d.shift = sw_word(d.sw, q.vco_word);
                        d.xcnt = 5'h00;
                        d.st = vco_cal_pkg::DS_XFER;
                    end
                end
            end
            vco_cal_pkg::DS_LOAD: begin
                d.mod_int = q.intg;
                d.mod_frac = q.frac_pend;
                d.mod_load = 1'b1;
                d.done = 1'b1;
                d.busy = 1'b0;
                d.st = vco_cal_pkg::DS_IDLE;
            end
            default: d.st = vco_cal_pkg::DS_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            q <= '0;
            q.st <= vco_cal_pkg::DS_IDLE;
            q.cfg <= vco_cal_pkg::CFG_RESET;
            q.rdiv <= vco_cal_pkg::RDIV_RESET;
            q.intg <= vco_cal_pkg::INTG_RESET;
        end else begin
            q <= d;
        end
    end

    assign vco_serial_clock_o = q.sclk;
    assign vco_serial_data_o = q.sdat;
    assign vco_serial_enable_o = q.sen;
    assign mod_int_o = q.mod_int;
    assign mod_frac_o = q.mod_frac;
    assign mod_load_o = q.mod_load;
    assign vtune_hold_o = q.vhold;
    assign port.busy = q.busy;
    assign port.cal_done = q.done;
    assign port.sw_state = q.sw;
    assign port.cal_error = q.err;
endmodule : vco_cal_device

// >>> rtl/vco_cal_host.sv
`timescale 1ns/1ps
module vco_cal_host (
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic resetn_i,
    // User commands
    input wire logic op_valid_i,
    input wire vco_cal_pkg::host_op_t op_i,
    input wire logic doubler_i,
    input wire logic retune_i,
    input wire logic [7:0] addr_i,
    input wire logic [23:0] data_i,
    output logic op_ready_o,
    // Main port to the device
    synth_port_if.host port
);
    typedef struct packed {
        vco_cal_pkg::host_state_t st;
        logic [23:0] first;
        logic [7:0] addr;
        logic second;
        logic ready;
        logic wr_valid;
        logic [7:0] wr_addr;
        logic [23:0] wr_data;
    } host_reg_t;

    host_reg_t q;
    host_reg_t d;

    always_comb begin
        d = q;
        d.wr_valid = 1'b0;
        case (q.st)
            vco_cal_pkg::HS_IDLE: begin
                if (op_valid_i && q.ready) begin
                    d.ready = 1'b0;
                    d.addr = vco_cal_pkg::ADDR_VCO_PORT;
                    d.second = 1'b0;
                    d.st = vco_cal_pkg::HS_FIRST;
                    case (op_i)
                        vco_cal_pkg::OP_PRECONFIG: d.first = vco_cal_pkg::VCO_PRECONFIG;
                        vco_cal_pkg::OP_MUTE: begin
                            d.first = doubler_i ? vco_cal_pkg::VCO_MUTE_DBL
                                                : vco_cal_pkg::VCO_MUTE_FUND;
                            d.second = retune_i;
                        end
                        vco_cal_pkg::OP_UNMUTE: begin
                            d.first = doubler_i ? vco_cal_pkg::VCO_UNMUTE_DBL
                                                : vco_cal_pkg::VCO_UNMUTE_FUND;
                            d.second = 1'b1;
                        end
                        vco_cal_pkg::OP_BIST_MAX: d.first = vco_cal_pkg::VCO_CLEAR;
                        default: begin
                            d.addr = addr_i;
                            d.first = data_i;
                            // Reference runs at twice the state clock limit, so m=0 is lifted
                            if (addr_i == vco_cal_pkg::ADDR_CFG &&
                                data_i[vco_cal_pkg::CFG_DIV_LO +: 2] == 2'h0) begin
                                d.first[vco_cal_pkg::CFG_DIV_LO +: 2] = vco_cal_pkg::DIV_SAFE;
                            end
                        end
                    endcase
                end
            end
            vco_cal_pkg::HS_FIRST: begin
                if (!port.busy) begin
                    d.wr_valid = 1'b1;
                    d.wr_addr = q.addr;
                    d.wr_data = q.first;
                    d.st = q.second ? vco_cal_pkg::HS_SECOND : vco_cal_pkg::HS_HOLD;
                end
            end
            vco_cal_pkg::HS_SECOND: begin
                // Let the first word's busy clear before the zero
                if (!port.busy && !q.wr_valid) begin
                    d.wr_valid = 1'b1;
                    d.wr_addr = vco_cal_pkg::ADDR_VCO_PORT;
                    d.wr_data = vco_cal_pkg::VCO_CLEAR;
                    d.st = vco_cal_pkg::HS_HOLD;
                end
            end
            vco_cal_pkg::HS_HOLD: begin
                if (!port.busy && !q.wr_valid) begin
                    d.ready = 1'b1;
                    d.st = vco_cal_pkg::HS_IDLE;
                end
            end
            default: d.st = vco_cal_pkg::HS_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            q <= '0;
            q.st <= vco_cal_pkg::HS_IDLE;
            q.ready <= 1'b1;
        end else begin
            q <= d;
        end
    end

    assign op_ready_o = q.ready;
    assign port.wr_valid = q.wr_valid;
    assign port.wr_addr = q.wr_addr;
    assign port.wr_data = q.wr_data;
endmodule : vco_cal_host

// >>> tb/vco_cal_monitor.sv
`timescale 1ns/1ps
module vco_cal_monitor (
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic resetn_i,
    // Main port signals
    input wire logic wr_valid,
    input wire logic [7:0] wr_addr,
    input wire logic [23:0] wr_data,
    input wire logic busy,
    input wire logic cal_done,
    input wire logic [vco_cal_pkg::SW_W-1:0] sw_state,
    input wire logic [vco_cal_pkg::ERR_W-1:0] cal_error
);
    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (!resetn_i);

    // Shadow of accepted settings for the time limits
    logic [15:0] cfg_q;
    logic [vco_cal_pkg::RDIV_W-1:0] rdiv_q;
    logic port_q;
    logic run_q;
    logic [15:0] len_q;
    logic take;
    logic wr_frac;
    int m_v;
    int n_v;
    int k_v;
    int win_v;

    assign take = wr_valid && !busy;
    assign wr_frac = take && wr_addr == vco_cal_pkg::ADDR_FRAC;

    always_comb begin
        k_v = int'(cfg_q[7:6]);
        n_v = (cfg_q[2:0] < 3'h4) ? int'(cfg_q[2:0]) : int'(cfg_q[2:0]) + 1;
        m_v = (cfg_q[14:13] == 2'h3) ? 5 : 2 * int'(cfg_q[14:13]);
        win_v = int'(rdiv_q) << n_v;
    end

    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            cfg_q <= vco_cal_pkg::CFG_RESET;
            rdiv_q <= vco_cal_pkg::RDIV_RESET;
            port_q <= 1'b0;
            run_q <= 1'b0;
            len_q <= 16'h0000;
        end else begin
            len_q <= busy ? len_q + 16'h0001 : 16'h0000;
            if (take) begin
                port_q <= wr_addr == vco_cal_pkg::ADDR_VCO_PORT;
                run_q <= wr_addr == vco_cal_pkg::ADDR_FRAC && !cfg_q[11];
                if (wr_addr == vco_cal_pkg::ADDR_CFG) cfg_q <= wr_data[15:0];
                if (wr_addr == vco_cal_pkg::ADDR_RDIV) rdiv_q <= wr_data[vco_cal_pkg::RDIV_W-1:0];
            end
        end
    end

    sequence s_unmute;
        wr_valid && wr_addr == vco_cal_pkg::ADDR_VCO_PORT
            && (wr_data == 24'h002018 || wr_data == 24'h002898);
    endsequence
    sequence s_clear;
        wr_valid && wr_addr == vco_cal_pkg::ADDR_VCO_PORT && wr_data == 24'h000000;
    endsequence
    sequence s_direct;
        !busy ##1 cal_done;
    endsequence

    a_port_busy: assert property (take && wr_addr == vco_cal_pkg::ADDR_VCO_PORT |=> busy)
        else $error("port write did not start a transfer");
    a_cal_start: assert property (wr_frac && !cfg_q[11] |=> busy)
        else $error("fraction write did not start calibration");
    a_cal_bypass: assert property (wr_frac && cfg_q[11] |=> s_direct)
        else $error("fraction not loaded directly");
    a_done_pulse: assert property (cal_done |=> !cal_done)
        else $error("done longer than one cycle");
    a_xfer_time: assert property ($fell(busy) && port_q |-> len_q >= (19 << m_v)
        && len_q <= (21 << m_v) + 2)
        else $error("transfer length wrong");
    a_search_time: assert property ($fell(busy) && run_q && !cfg_q[10]
        |-> len_q >= 5 * win_v + ((128 * k_v) << m_v)
        && len_q <= 6 * win_v + ((156 + 768 * k_v) << m_v))
        else $error("calibration length wrong");
    a_frozen_time: assert property ($fell(busy) && run_q && cfg_q[10]
        |-> len_q >= win_v && len_q <= 2 * win_v + ((48 + 128 * k_v) << m_v))
        else $error("frozen measurement length wrong");
    a_sw_frozen: assert property (busy && $past(busy) && run_q && cfg_q[10] |-> $stable(sw_state))
        else $error("switch moved while frozen");
    a_err_idle: assert property (!busy && !$past(busy) |-> $stable(cal_error))
        else $error("count error changed while idle");
    a_div_safe: assert property (wr_valid && wr_addr == vco_cal_pkg::ADDR_CFG |-> wr_data[14:13] != 2'h0)
        else $error("host allowed full-rate state clock");
    a_unmute_clear: assert property (s_unmute |-> ##[1:1000] s_clear)
        else $error("unmute not followed by clear");
endmodule : vco_cal_monitor

// >>> tb/testbench.sv
`timescale 1ns/1ps
module testbench;
    logic ref_clk, resetn, op_valid, dbl, rt, op_ready, vco_pulse, vtune_a;
    logic sclk_b, sdat_b, sen_b, load_b, en_p;
    vco_cal_pkg::host_op_t op;
    logic [7:0] addr;
    logic [23:0] data, f, frac_a, frac_b;
    logic [23:0] words [$];
    logic [23:0] exp_q [$];
    logic [15:0] bits, w;
    int failures, n_tests, cyc, seed, en_n, en_r, pn, ld_n;

    synth_port_if if_a ();
    synth_port_if if_b ();
    vco_cal_host vco_cal_host_i (.ref_clk_i(ref_clk), .resetn_i(resetn), .op_valid_i(op_valid),
        .op_i(op), .doubler_i(dbl), .retune_i(rt), .addr_i(addr), .data_i(data),
        .op_ready_o(op_ready), .port(if_a));
    vco_cal_device vco_cal_device_i (.ref_clk_i(ref_clk), .resetn_i(resetn), .port(if_a),
        .vco_pulse_i(vco_pulse), .vco_serial_clock_o(), .vco_serial_data_o(),
        .vco_serial_enable_o(), .mod_int_o(), .mod_frac_o(frac_a), .mod_load_o(),
        .vtune_hold_o(vtune_a));
    // Raw second device takes settings no host would send
    vco_cal_device b_vco_cal_device_i (.ref_clk_i(ref_clk), .resetn_i(resetn), .port(if_b),
        .vco_pulse_i(vco_pulse), .vco_serial_clock_o(sclk_b), .vco_serial_data_o(sdat_b),
        .vco_serial_enable_o(sen_b), .mod_int_o(), .mod_frac_o(frac_b), .mod_load_o(load_b),
        .vtune_hold_o());
    vco_cal_monitor vco_cal_monitor_i (.ref_clk_i(ref_clk), .resetn_i(resetn),
        .wr_valid(if_a.wr_valid), .wr_addr(if_a.wr_addr), .wr_data(if_a.wr_data),
        .busy(if_a.busy), .cal_done(if_a.cal_done), .sw_state(if_a.sw_state),
        .cal_error(if_a.cal_error));

    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    // VCO at half the reference rate
    always begin
        @(posedge ref_clk);
        #1;
        vco_pulse = ~vco_pulse;
    end
    always @(posedge ref_clk) begin
        if (if_a.wr_valid && if_a.wr_addr == 8'h05) words.push_back(if_a.wr_data);
        en_p <= sen_b;
        if (sen_b) en_n++;
        if (sen_b && !en_p) en_r++;
        if (load_b) ld_n++;
        if (sclk_b) bits = {bits[14:0], sdat_b};
        if (sclk_b) pn++;
        cyc++;
        if (cyc == 20000) begin
            failures++;
            complete_run();
        end
    end

    function automatic logic [23:0] first_word(input vco_cal_pkg::host_op_t o, input logic d);
        case (o)
            vco_cal_pkg::OP_PRECONFIG: return 24'h000188;
            vco_cal_pkg::OP_MUTE: return d ? 24'h002218 : 24'h002a98;
            vco_cal_pkg::OP_UNMUTE: return d ? 24'h002018 : 24'h002898;
            default: return 24'h000000;
        endcase
    endfunction : first_word
    // Window is 2 * 2^n cycles at R=2, so the VCO gives 2^n edges
    function automatic longint exp_err(input logic [23:0] fr, input int c);
        int n;
        longint nv;
        n = (c < 4) ? c : c + 1;
        nv = longint'({vco_cal_pkg::INTG_RESET, fr});
        return (longint'(1) << n) - ((nv << n) >> 24);
    endfunction : exp_err
    function automatic int m_of(input int d);
        return (d == 0) ? 0 : (d == 1) ? 2 : (d == 2) ? 4 : 5;
    endfunction : m_of

    task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
        n_tests++;
        if (s !== e) begin
            failures++;
            $display("FAIL %s exp %h seen %h", nm, e, s);
        end
    endtask : chk
    // Window and VCO phase are unrelated: allow one count
    task automatic chk_err(input logic [19:0] s, input logic [19:0] v);
        n_tests++;
        if (s !== v && s !== v - 20'h00001 && s !== v + 20'h00001) begin
            failures++;
            $display("FAIL count error exp %h seen %h", v, s);
        end
    endtask : chk_err
    task automatic wait_rdy();
        while (op_ready !== 1'b1) begin
            @(posedge ref_clk);
            #1;
        end
    endtask : wait_rdy
    task automatic hop(input vco_cal_pkg::host_op_t o, input logic d, input logic r,
                       input logic [7:0] a, input logic [23:0] v);
        wait_rdy();
        op_valid = 1'b1;
        op = o;
        dbl = d;
        rt = r;
        addr = a;
        data = v;
        @(posedge ref_clk);
        #1;
        op_valid = 1'b0;
        wait_rdy();
    endtask : hop
    task automatic wr_a(input logic [7:0] a, input logic [23:0] v);
        hop(vco_cal_pkg::OP_WRITE, 1'b0, 1'b0, a, v);
    endtask : wr_a
    task automatic bw(input logic [7:0] a, input logic [23:0] v);
        if_b.wr_valid = 1'b1;
        if_b.wr_addr = a;
        if_b.wr_data = v;
        @(posedge ref_clk);
        #1;
        if_b.wr_valid = 1'b0;
        @(posedge ref_clk);
        #1;
    endtask : bw
    task automatic wait_b();
        while (if_b.busy !== 1'b0) begin
            @(posedge ref_clk);
            #1;
        end
        repeat (2) @(posedge ref_clk);
        #1;
    endtask : wait_b
    task automatic complete_run();
        if (failures == 0 && n_tests > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : complete_run

    initial begin
        seed = $urandom(19729);
        {resetn, op_valid, dbl, rt, vco_pulse} = 5'h00;
        {addr, data, bits} = 48'h0;
        op = vco_cal_pkg::OP_WRITE;
        {if_b.wr_valid, if_b.wr_addr, if_b.wr_data} = 33'h0;
        repeat (6) @(posedge ref_clk);
        #1;
        resetn = 1'b1;
        // Ops 1, 2, 2, 3, 3, 4 in turn
        for (int i = 0; i < 6; i++) begin
            vco_cal_pkg::host_op_t o;
            o = vco_cal_pkg::host_op_t'(3'((i + 3) / 2));
            hop(o, i[0], i == 2, 8'h00, 24'h000000);
            exp_q.push_back(first_word(o, i[0]));
            if (i == 2 || o == vco_cal_pkg::OP_UNMUTE) exp_q.push_back(24'h000000);
        end
        chk("word count", words.size(), exp_q.size());
        foreach (exp_q[j]) chk("port word", words[j], exp_q[j]);
        wr_a(vco_cal_pkg::ADDR_RDIV, 24'h000002);
        for (int c = 0; c < 8; c++) begin
            f = (c == 0) ? 24'h000000 : (c == 7) ? 24'hffffff : 24'($urandom);
            wr_a(vco_cal_pkg::ADDR_CFG, 24'h000400 | 24'(c));
            wr_a(vco_cal_pkg::ADDR_FRAC, f);
            chk("varactor hold", vtune_a, 1'b1);
            chk_err(if_a.cal_error, 20'(exp_err(f, c)));
        end
        f = 24'($urandom);
        wr_a(vco_cal_pkg::ADDR_CFG, 24'h000040);
        wr_a(vco_cal_pkg::ADDR_FRAC, f);
        chk("loaded fraction", frac_a, f);
        chk("varactor free", vtune_a, 1'b0);
        f = 24'($urandom);
        wr_a(vco_cal_pkg::ADDR_CFG, 24'h000800);
        wr_a(vco_cal_pkg::ADDR_FRAC, f);
        repeat (3) @(posedge ref_clk);
        #1;
        chk("direct fraction", frac_a, f);
        for (int d = 0; d < 4; d++) begin
            w = (d == 0) ? 16'h8001 : 16'($urandom);
            bw(vco_cal_pkg::ADDR_CFG, 24'h000800 | (24'(d) << 13));
            wait_b();
            en_n = 0;
            pn = 0;
            bw(vco_cal_pkg::ADDR_VCO_PORT, {8'h00, w});
            wait_b();
            chk("enable cycles", en_n, 20 << m_of(d));
            chk("link clocks", pn, 16);
            chk("link word", bits, w);
        end
        bw(vco_cal_pkg::ADDR_CFG, 24'h000040);
        wait_b();
        {en_r, pn, ld_n} = 96'h0;
        f = 24'($urandom);
        bw(vco_cal_pkg::ADDR_FRAC, f);
        bw(vco_cal_pkg::ADDR_FRAC, ~f);
        wait_b();
        chk("transfers", en_r, 6);
        chk("search clocks", pn, 96);
        chk("loads", ld_n, 1);
        chk("kept fraction", frac_b, f);
        complete_run();
    end
endmodule : testbench
